// *** verilog/loc_pkg.sv ***
// Constants, register map and types of the latched output clear control.
// Assumes a 100 MHz clock and a classic Wishbone slave interface.
`default_nettype none
package loc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int HOLD_MS = 1000;
    localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
    localparam int TEST_MS = 1000;
    localparam int TEST_CYC = CLK_HZ / 1000 * TEST_MS;
    localparam int NSG = 4;
    localparam int NLED = 8;
    localparam int NBO = 8;
    localparam int NSC = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_PWD = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    // Command bits
    localparam int C_SYS = 0;
    localparam int C_LED = 1;
    localparam int C_BO = 2;
    localparam int C_SC = 3;
    localparam int C_ALL = 4;
    localparam int C_CONF = 5;
    localparam int C_SG = 8;
    // Control bits
    localparam int K_REM = 0;
    localparam int K_SCL = 1;
    localparam int K_SCW = 3;
    localparam int K_EMPTY = 4;
    localparam int K_SEL = 8;
    localparam logic [2:0] SCOPE_RST = 3'h1;
    localparam logic [2:0] SCOPE_NONE = 3'h0;
    localparam logic [2:0] SCOPE_LED_NP = 3'h1;
    localparam logic [2:0] SCOPE_LED = 3'h2;
    localparam logic [2:0] SCOPE_LED_BO = 3'h3;
    localparam logic [2:0] SCOPE_ALL = 3'h4;
    // Password value is arbitrary
    localparam logic [15:0] PWD_LVL1 = 16'h5a5a;
    typedef enum logic [1:0] {LT_IDLE, LT_RED, LT_GREEN} loc_test_t;
endpackage : loc_pkg
`default_nettype wire

// *** verilog/loc_clear_ctrl.sv ***
// Latched output clear controller with Wishbone register access.
// Assumes key, setting mode and latch inputs synchronous to clock.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
module loc_clear_ctrl
    import loc_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int TEST_CYCLES = TEST_CYC
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic clearKey,
    input wire logic settingMode,
    input wire logic [NLED-1:0] ledSet,
    input wire logic [NBO-1:0] relaySet,
    input wire logic [NBO-1:0] offDelayDone,
    input wire logic [NSC-1:0] telemSet,
    input wire logic [NSG-1:0] tripSet,
    input wire logic sysWarnSet,
    input wire logic extLedClear,
    input wire logic extRelayClear,
    input wire logic extTelemClear,
    output logic [NLED-1:0] ledLatch,
    output logic [NBO-1:0] relayLatch,
    output logic [NSC-1:0] telemLatch,
    output logic [NSG-1:0] tripLatch,
    output logic sysWarn,
    output logic menuOpen,
    output logic pwdPrompt,
    output logic testRed,
    output logic testGreen
);
    // Clear mask: [0]sys [1]led [2]relay [3]telem [4+i] trip i
    localparam int MW = 4 + NSG;

    function automatic logic [MW-1:0] scopeMask(input logic [2:0] s);
        logic [MW-1:0] m;
        m = '0;
        unique case (s)
            SCOPE_LED_NP, SCOPE_LED: m[1] = 1'b1;
            SCOPE_LED_BO: m[2:1] = 2'b11;
            SCOPE_ALL: m = {{NSG{1'b1}}, 3'b111, 1'b0};
            default: m = '0;
        endcase
        return m;
    endfunction : scopeMask

    logic rs1_r, rs2_r;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end
        else
        begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    wire logic rstn = rs2_r;

    logic [31:0] ctrl_r, ctrl_nxt, rdat_r, rdat_nxt;
    logic ack_r, ack_nxt;
    logic [NLED-1:0] led_r, led_nxt;
    logic [NBO-1:0] bo_r, bo_nxt, boPend_r, boPend_nxt;
    logic [NSC-1:0] sc_r, sc_nxt;
    logic [NSG-1:0] sg_r, sg_nxt;
    logic sys_r, sys_nxt, menu_r, menu_nxt, prm_r, prm_nxt;
    logic [MW-1:0] held_r, held_nxt;
    logic key_r, key_nxt, long_r, long_nxt;
    logic [31:0] kcnt_r, kcnt_nxt, tcnt_r, tcnt_nxt;
    loc_test_t tst_r, tst_nxt;

    always_comb
    begin
        logic wr, rd;
        logic [MW-1:0] req;
        logic [MW-1:0] clr;
        logic needPwd;
        wr = 1'b0;
        rd = 1'b0;
        req = '0;
        clr = '0;
        needPwd = 1'b0;
        ctrl_nxt = ctrl_r;
        rdat_nxt = rdat_r;
        ack_nxt = 1'b0;
        menu_nxt = menu_r;
        prm_nxt = prm_r;
        held_nxt = held_r;
        key_nxt = clearKey;
        long_nxt = long_r;
        kcnt_nxt = kcnt_r;
        tst_nxt = tst_r;
        tcnt_nxt = tcnt_r;
        if (wb_cyc_i && wb_stb_i && !ack_r)
        begin
            ack_nxt = 1'b1;
            wr = wb_we_i;
            rd = !wb_we_i;
        end
        if (rd)
        begin
            unique case (wb_adr_i)
                ADR_CTRL: rdat_nxt = ctrl_r;
                ADR_STAT: rdat_nxt = {8'h00, 3'h0, prm_r, menu_r, 1'b0,
                    tst_r, tripLatch, 3'h0, sysWarn, ledLatch};
                default: rdat_nxt = 32'h0000_0000;
            endcase
        end
        if (wr && wb_adr_i == ADR_CTRL)
        begin
            for (int b = 0; b < 4; b++)
                if (wb_sel_i[b])
                    ctrl_nxt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
        // Register commands count as remote requests, or as local ones while the menu is open
        if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0]
            && (ctrl_r[K_REM] || menu_r))
        begin
            req[0] = wb_dat_i[C_SYS];
            req[1] = wb_dat_i[C_LED];
            req[2] = wb_dat_i[C_BO];
            req[3] = wb_dat_i[C_SC];
            if (wb_dat_i[C_ALL])
                req = req | {{NSG{1'b1}}, 3'b111, 1'b0};
            if (wb_sel_i[1])
                req[MW-1:4] = req[MW-1:4] | wb_dat_i[C_SG +: NSG];
        end
        // Confirm softkey applies the menu selection
        if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && menu_r
            && wb_dat_i[C_CONF])
        begin
            req = req | ctrl_r[K_SEL +: MW];
            menu_nxt = 1'b0;
        end
        // External clear inputs share the remote gate
        if (ctrl_r[K_REM])
            req[3:1] = req[3:1] | {extTelemClear, extRelayClear, extLedClear};
        // Key classification, disabled in setting mode
        if (clearKey && !settingMode)
        begin
            if (kcnt_r < 32'(HOLD_CYCLES))
                kcnt_nxt = kcnt_r + 32'h1;
            if (kcnt_r == 32'(HOLD_CYCLES - 1) && !long_r)
            begin
                long_nxt = 1'b1;
                req = req | scopeMask(ctrl_r[K_SCL +: K_SCW]);
            end
        end
        else
        begin
            kcnt_nxt = '0;
            long_nxt = 1'b0;
            if (key_r && !clearKey && !long_r && !settingMode)
                menu_nxt = 1'b1;
        end
        // Password needed for relay, telem or trip clears unless K_EMPTY is set, and for an indicator-only long press with SCOPE_LED
        needPwd = |req[MW-1:2] && !ctrl_r[K_EMPTY];
        if (req[1] && !(|req[MW-1:2]) && ctrl_r[K_SCL +: K_SCW] == SCOPE_LED
            && long_nxt && !long_r)
            needPwd = 1'b1;
        if (prm_r)
        begin
            held_nxt = held_r | req;
            if (wr && wb_adr_i == ADR_PWD && wb_sel_i[1:0] == 2'b11)
            begin
                prm_nxt = 1'b0;
                held_nxt = '0;
                if (wb_dat_i[15:0] == PWD_LVL1)
                    clr = held_r | req;
            end
        end
        else if (needPwd)
        begin
            prm_nxt = 1'b1;
            held_nxt = req;
        end
        else
            clr = req;
        // Indicator test sequence
        if (clr[1])
        begin
            tst_nxt = LT_RED;
            tcnt_nxt = '0;
        end
        else if (tst_r != LT_IDLE)
        begin
            tcnt_nxt = tcnt_r + 32'h1;
            if (tcnt_r == 32'(TEST_CYCLES - 1))
            begin
                tcnt_nxt = '0;
                unique case (tst_r)
                    LT_RED: tst_nxt = LT_GREEN;
                    LT_GREEN: tst_nxt = LT_IDLE;
                    default: tst_nxt = LT_IDLE;
                endcase
            end
        end
        // Latch updates: a set in the same cycle wins over a clear
        sys_nxt = (sys_r && !clr[0]) || sysWarnSet;
        led_nxt = (clr[1] ? '0 : led_r) | ledSet;
        sc_nxt = (clr[3] ? '0 : sc_r) | telemSet;
        sg_nxt = (sg_r & ~clr[MW-1:4]) | tripSet;
        // Relay release waits for off-delay done
        boPend_nxt = (clr[2] ? bo_r : boPend_r) & ~offDelayDone;
        bo_nxt = (bo_r & ~(offDelayDone & (boPend_r | (clr[2] ? bo_r : '0))))
            | relaySet;
        boPend_nxt = boPend_nxt & ~relaySet;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_r <= {28'h0, SCOPE_RST, 1'b0};
            rdat_r <= '0;
            ack_r <= 1'b0;
            led_r <= '0;
            bo_r <= '0;
            boPend_r <= '0;
            sc_r <= '0;
            sg_r <= '0;
            sys_r <= 1'b0;
            menu_r <= 1'b0;
            prm_r <= 1'b0;
            held_r <= '0;
            key_r <= 1'b0;
            long_r <= 1'b0;
            kcnt_r <= '0;
            tcnt_r <= '0;
            tst_r <= LT_IDLE;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            rdat_r <= rdat_nxt;
            ack_r <= ack_nxt;
            led_r <= led_nxt;
            bo_r <= bo_nxt;
            boPend_r <= boPend_nxt;
            sc_r <= sc_nxt;
            sg_r <= sg_nxt;
            sys_r <= sys_nxt;
            menu_r <= menu_nxt;
            prm_r <= prm_nxt;
            held_r <= held_nxt;
            key_r <= key_nxt;
            long_r <= long_nxt;
            kcnt_r <= kcnt_nxt;
            tcnt_r <= tcnt_nxt;
            tst_r <= tst_nxt;
        end
    end

    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;
    assign ledLatch = led_r;
    assign relayLatch = bo_r;
    assign telemLatch = sc_r;
    assign tripLatch = sg_r;
    assign sysWarn = sys_r;
    assign menuOpen = menu_r;
    assign pwdPrompt = prm_r;
    assign testRed = (tst_r == LT_RED);
    assign testGreen = (tst_r == LT_GREEN);
endmodule : loc_clear_ctrl
`default_nettype wire

// *** dv/loc_clear_ctrl_asserts.sv ***
// Port checker for the clear controller.
// Bound into the top module; sees its ports only.
`default_nettype none
module loc_clear_ctrl_asserts
    import loc_pkg::*;
#(
    parameter int TEST_CYCLES = TEST_CYC
)(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic settingMode,
    input wire logic [NLED-1:0] ledSet,
    input wire logic [NSG-1:0] tripSet,
    input wire logic sysWarnSet,
    input wire logic [NLED-1:0] ledLatch,
    input wire logic [NSG-1:0] tripLatch,
    input wire logic sysWarn,
    input wire logic menuOpen,
    input wire logic pwdPrompt,
    input wire logic testRed,
    input wire logic testGreen
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic remEn_r;
    logic emptyPw_r;
    int redCnt_r;
    int grnCnt_r;
    wire cmdW = wb_ack_o && wb_we_i && wb_adr_i == ADR_CMD &&
        wb_sel_i[1:0] == 2'h3;
    // Shadow of control bits, since the checker cannot see registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remEn_r <= 1'h0;
            emptyPw_r <= 1'h0;
            redCnt_r <= 0;
            grnCnt_r <= 0;
        end
        else
        begin
            if (wb_ack_o && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0])
            begin
                remEn_r <= wb_dat_i[K_REM];
                emptyPw_r <= wb_dat_i[K_EMPTY];
            end
            redCnt_r <= testRed ? redCnt_r + 1 : 0;
            grnCnt_r <= testGreen ? grnCnt_r + 1 : 0;
        end
    end
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_ACK_CAUSE: assert property
        ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_REMOTE_OFF: assert property (
        cmdW && !remEn_r && !menuOpen |=> ($past(ledLatch) & ~ledLatch) == 0)
        else $error("remote clear acted while disabled");
    AST_OWN_CAT: assert property (
        cmdW && !wb_dat_i[C_LED] && !wb_dat_i[C_ALL] && !wb_dat_i[C_CONF]
        |=> ($past(ledLatch) & ~ledLatch) == 0)
        else $error("indicators cleared by other command");
    AST_ONE_SG: assert property (
        cmdW && !wb_dat_i[C_ALL] && !wb_dat_i[C_CONF] |=> ($past(tripLatch)
        & ~tripLatch & ~$past(wb_dat_i[C_SG+:NSG])) == 0)
        else $error("wrong switchgear trip cleared");
    AST_COMBINED: assert property (
        cmdW && wb_dat_i[C_ALL] && remEn_r && emptyPw_r && !pwdPrompt
        |=> (ledLatch & ~$past(ledSet)) == 0 &&
        (tripLatch & ~$past(tripSet)) == 0)
        else $error("combined clear incomplete");
    AST_SYS_CLEAR: assert property (
        cmdW && wb_dat_i[C_SYS] && remEn_r |=> !sysWarn || $past(sysWarnSet))
        else $error("system warning not cleared");
    AST_SETTING: assert property (
        settingMode && $past(settingMode) && $past(settingMode, 2) &&
        !menuOpen |=> !menuOpen)
        else $error("key acted in setting mode");
    AST_RED_LEN: assert property (
        $fell(testRed) |-> testGreen && redCnt_r == TEST_CYCLES)
        else $error("red test phase length wrong");
    AST_GREEN_LEN: assert property (
        $fell(testGreen) && !testRed |-> grnCnt_r == TEST_CYCLES)
        else $error("green test phase length wrong");
    CVR_TEST: cover property ($rose(testRed));
    CVR_PROMPT: cover property ($fell(pwdPrompt));
    CVR_MENU: cover property ($fell(menuOpen));
endmodule : loc_clear_ctrl_asserts
bind loc_clear_ctrl loc_clear_ctrl_asserts #(.TEST_CYCLES(TEST_CYCLES))
    i_chk (.*);
`default_nettype wire

// *** dv/loc_panel_model.sv ***
// Clear key of the operator panel.
// Holds the key down for a requested number of cycles.
`default_nettype none
module loc_panel_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] len,
    output logic clearKey
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r = 8'h0;
    // No bounce modelled; the key is still between presses
    always_ff @(posedge clock)
    begin
        cnt_r <= go ? len : cnt_r - 8'(cnt_r != 8'h0);
    end
    assign clearKey = cnt_r != 8'h0;
endmodule : loc_panel_model
`default_nettype wire

// *** dv/loc_clear_ctrl_tb.sv ***
// Self-checking bench of the clear controller.
// Drives bus, latch sets and the panel key model.
`default_nettype none
module loc_clear_ctrl_tb
    import loc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'h0, rst_b = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic setMode = 1'h0, kGo = 1'h0, extLed = 1'h0, key, ack;
    logic menu, prompt, red;
    logic [7:0] adr = 8'h0, kLen = 8'h0, ledSet = 8'h0, offDone = 8'hff;
    logic [3:0] tripSet = 4'h0;
    logic [15:0] lf = 16'hada6;
    logic [31:0] dat = 32'h0, rd, rdat;
    int errors = 0, n_compared = 0, mLed = 0, mTrip = 0;
    int held[$];
    loc_panel_model i_key (.clock(clock), .go(kGo), .len(kLen),
        .clearKey(key));
    loc_clear_ctrl #(.HOLD_CYCLES(20), .TEST_CYCLES(10)) i_dut (
        .clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .clearKey(key),
        .settingMode(setMode), .ledSet(ledSet), .relaySet(ledSet),
        .offDelayDone(offDone), .telemSet(ledSet), .tripSet(tripSet),
        .sysWarnSet(ledSet[0]), .extLedClear(extLed),
        .extRelayClear(extLed), .extTelemClear(extLed), .ledLatch(),
        .relayLatch(), .telemLatch(), .tripLatch(), .sysWarn(),
        .menuOpen(menu), .pwdPrompt(prompt), .testRed(red), .testGreen());
    initial forever #5 clock = ~clock;
    task test_done;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task chk(input string nm, input int e, input logic [31:0] g);
        n_compared++;
        if (g !== 32'(e))
        begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        @(posedge clock);
        while (ack !== 1'h1)
            @(posedge clock);
        rd = rdat;
        {cyc, stb} <= 2'h0;
    endtask : wb
    task st;
        wb(1'h0, ADR_STAT, 32'h0);
        chk("led", mLed, {24'h0, rd[7:0]});
        chk("trip", mTrip, {28'h0, rd[15:12]});
    endtask : st
    // Sets are pulsed and gone before any clear, so no set-wins overlap
    task setl;
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        @(posedge clock);
        ledSet <= lf[7:0] | 8'h1;
        tripSet <= lf[11:8] | 4'h1;
        @(posedge clock);
        {ledSet, tripSet} <= 12'h0;
        mLed |= lf[7:0] | 8'h1;
        mTrip |= lf[11:8] | 4'h1;
    endtask : setl
    task press(input logic [7:0] n);
        @(posedge clock);
        {kGo, kLen} <= {1'h1, n};
        @(posedge clock);
        kGo <= 1'h0;
        repeat (40) @(posedge clock);
    endtask : press
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done;
    end
    initial
    begin
        repeat (12) @(posedge clock);
        rst_b <= 1'h1;
        repeat (3) @(posedge clock);
        wb(1'h0, ADR_CTRL, 32'h0);
        chk("ctrl", 'h2, rd);
        setl;
        press(8'h1e);
        mLed = 0;
        st;
        setl;
        wb(1'h1, ADR_CMD, 32'h12);
        st;
        @(posedge clock) extLed <= 1'h1;
        @(posedge clock) extLed <= 1'h0;
        st;
        setMode <= 1'h1;
        press(8'h5);
        chk("menu", 0, menu);
        setMode <= 1'h0;
        press(8'h5);
        chk("menu", 1, menu);
        st;
        wb(1'h1, ADR_CTRL, 32'h202);
        wb(1'h1, ADR_CMD, 32'h20);
        mLed = 0;
        repeat (3) @(negedge clock);
        chk("red", 1, red);
        st;
        repeat (30) @(posedge clock);
        wb(1'h1, ADR_CTRL, 32'h13);
        setl;
        wb(1'h1, ADR_CMD, 32'h4);
        st;
        for (int i = 0; i < NSG; i++)
        begin
            wb(1'h1, ADR_CMD, 32'h100 << i);
            mTrip &= ~(1 << i);
            st;
        end
        setl;
        wb(1'h1, ADR_CMD, 32'h10);
        {mLed, mTrip} = 0;
        st;
        wb(1'h1, ADR_CMD, 32'h1);
        st;
        chk("sys", 0, rd[8]);
        repeat (30) @(posedge clock);
        wb(1'h1, ADR_CTRL, 32'h3);
        setl;
        wb(1'h1, ADR_CMD, 32'h100);
        held.push_back(1);
        st;
        chk("prompt", 1, rd[20]);
        wb(1'h1, ADR_PWD, 32'h1234);
        void'(held.pop_front());
        st;
        wb(1'h1, ADR_CMD, 32'h100);
        held.push_back(1);
        wb(1'h1, ADR_PWD, 32'h5a5a);
        mTrip &= ~held.pop_front();
        st;
        test_done;
    end
endmodule : loc_clear_ctrl_tb
`default_nettype wire
